// ===== hw/pbsq_pkg.sv
// Constants and types shared by the push-button and load-switch logic
package pbsq_pkg;
	// Time base
	localparam int CLK_MHZ    = 20;              // clk_sys rate in MHz
	localparam int TICK_US    = 1000;            // Press timer step, us
	localparam int TICK_CYC   = TICK_US * CLK_MHZ;
	localparam int INT_US     = 128;             // Host notify pulse, us
	localparam int INT_CYC    = INT_US * CLK_MHZ;
	localparam int DEB_US     = 50;              // Button settle time, us
	localparam int DEB_CYC    = DEB_US * CLK_MHZ;
	localparam int RST_MS     = 400;             // Reset pulse length, ms
	localparam int RST_CYC    = RST_MS * TICK_CYC;
	localparam int MS_W       = 14;              // Press timer width
	// Register offsets (byte addresses)
	localparam logic [3:0] OFS_PB   = 4'h0;      // Button control/flags
	localparam logic [3:0] OFS_LS   = 4'h4;      // Load output control
	localparam logic [3:0] OFS_SYS  = 4'h8;      // Status, buck control
	// Field positions
	localparam int PB_WSEL  = 0;                 // Wake time select [1:0]
	localparam int PB_HSEL  = 2;                 // Hold time select [3:2]
	localparam int PB_REC   = 4;                 // Recovery mode select
	localparam int PB_VREQ  = 5;                 // Supply required select
	localparam int PB_W1    = 8;                 // First wake flag
	localparam int PB_W2    = 9;                 // Second wake flag
	localparam int PB_RF    = 10;                // Reset fault flag
	localparam int LS_EN    = 0;                 // Output enable bit
	localparam int LS_CODE  = 8;                 // Voltage code [12:8]
	localparam int SYS_BOFF = 8;                 // Write 1: buck off
	// Reset values and output coding
	localparam int VCODE_W  = 5;
	localparam logic [VCODE_W-1:0] RST_VCODE  = 5'h1F;
	localparam logic [VCODE_W-1:0] VCODE_3V3  = 5'h19;
	localparam logic [11:0]        LDO_BASE   = 12'h320; // 800 mV
	localparam logic [11:0]        LDO_STEP   = 12'h064; // 100 mV
	// Operating modes
	typedef enum logic [1:0] {
		MODE_ACT  = 2'b00,
		MODE_SHIP = 2'b01,
		MODE_HIZ  = 2'b10
	} pbsq_mode_t;
	// Wake thresholds in ms, first and second flag
	function automatic logic [MS_W-1:0] wake_ms(input logic [1:0] s,
	                                            input logic second);
		logic [MS_W-1:0] b;
		unique case (s)
			2'b00: b = 14'h0032; // 50 ms
			2'b01: b = 14'h0064;
			2'b10: b = 14'h01F4;
			2'b11: b = 14'h03E8;
		endcase
		return second ? MS_W'({b, 1'b0}) : b;
	endfunction
	// Reset hold thresholds in ms
	function automatic logic [MS_W-1:0] hold_ms(input logic [1:0] s);
		logic [MS_W-1:0] b;
		unique case (s)
			2'b00: b = 14'h1388; // 5 s
			2'b01: b = 14'h2328;
			2'b10: b = 14'h2AF8;
			2'b11: b = 14'h3A98;
		endcase
		return b;
	endfunction
endpackage

// ===== hw/pbsq_btn_if.sv
// Filtered button state passed from the input filter to the sequencer
`timescale 1ns/1ps
`default_nettype none
interface pbsq_btn_if;
	logic pressed;  // Debounced button held low
	logic fall;     // One-cycle: press started
	modport src (output pressed, output fall);
	modport snk (input pressed, input fall);
endinterface
`default_nettype wire

// ===== hw/pbsq_btn_filter.sv
// Button synchroniser and debounce filter
`timescale 1ns/1ps
`default_nettype none
module pbsq_btn_filter import pbsq_pkg::*; #(
	parameter int DEB = DEB_CYC
) (
	// Clock and reset
	input  wire logic   clk_sys,
	input  wire logic   reset,
	// Raw pin and filtered result
	input  wire logic   pushbutton_in_n,
	pbsq_btn_if.src     btn
);
	localparam int CW = $clog2(DEB + 1);

	if (DEB < 1) begin : g_chk
		$error("pbsq_btn_filter: DEB must be at least one");
	end
	logic          meta_r;     // First stage, read only by sync_r
	logic          sync_r;     // Settled pin level
	logic [CW-1:0] cnt_r;      // Cycles the level has differed
	logic          pressed_r;  // Accepted level, high when held low
	logic          fall_r;     // Press start pulse

	// Two flops before any logic looks at the pin
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			meta_r <= 1'b1;
			sync_r <= 1'b1;
		end else begin
			meta_r <= pushbutton_in_n;
			sync_r <= meta_r;
		end
	end

	// Accept a new level only after it holds for DEB cycles
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			cnt_r     <= '0;
			pressed_r <= 1'b0;
			fall_r    <= 1'b0;
		end else begin
			fall_r <= 1'b0;
			if (pressed_r == sync_r) begin
				// Level differs from accepted state
				if (cnt_r == CW'(DEB - 1)) begin
					cnt_r     <= '0;
					pressed_r <= ~sync_r;
					fall_r    <= ~sync_r;
				end else begin
					cnt_r <= cnt_r + 1'b1;
				end
			end else begin
				cnt_r <= '0; // Bounce restarts the wait
			end
		end
	end

	assign btn.pressed = pressed_r;
	assign btn.fall    = fall_r;
endmodule // pbsq_btn_filter
`default_nettype wire

// ===== hw/pbsq_pulse.sv
// Retriggerable one-shot of a fixed length in clock cycles
`timescale 1ns/1ps
`default_nettype none
module pbsq_pulse #(
	parameter int LEN = 2560
) (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic reset,
	// Trigger and output
	input  wire logic trig,
	output logic      active
);
	localparam int CW = $clog2(LEN + 1);
	logic [CW-1:0] cnt_r;     // Cycles left after this one
	logic          active_r;  // Pulse level

	if (LEN < 1) begin : g_chk
		$error("pbsq_pulse: LEN must be at least one");
	end

	// Load on trigger, count down, drop after LEN cycles
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			cnt_r    <= '0;
			active_r <= 1'b0;
		end else if (trig) begin
			cnt_r    <= CW'(LEN - 1);
			active_r <= 1'b1;
		end else if (cnt_r != '0) begin
			cnt_r <= cnt_r - 1'b1;
		end else begin
			active_r <= 1'b0;
		end
	end

	assign active = active_r;
endmodule // pbsq_pulse
`default_nettype wire

// ===== hw/pbsq_top.sv
// Push-button wake/reset sequencer and load output selector
`timescale 1ns/1ps
`default_nettype none
module pbsq_top import pbsq_pkg::*; #(
	parameter int TICK    = TICK_CYC,
	parameter int RST_LEN = RST_CYC
) (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        reset,
	// Avalon-MM slave
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	// Pins from the system
	input  wire logic        pushbutton_in_n,
	input  wire logic        load_ctrl_pin,
	input  wire logic        bat_present,
	input  wire logic        vin_valid,
	input  wire logic        chg_enable,
	input  wire logic        vin_in_window,
	input  wire logic        load_fault,
	// Host outputs
	output logic             int_out_n,
	output logic             reset_out_n,
	output logic             power_good_out_n,
	// Load output and buck control
	output logic             load_on,
	output logic             load_pass_through,
	output logic             load_pulldown,
	output logic [11:0]      ldo_target_mv,
	output logic             buck_output_en
);
	if (TICK < 2 || RST_LEN < 1) begin : g_chk
		$error("pbsq_top: TICK must be >= 2 and RST_LEN >= 1");
	end
	localparam int TW = $clog2(TICK);

	// Pin synchroniser: pin, battery, vin, charge, window, fault
	logic [5:0] meta_r;     // First stage, read only by sync_r
	logic [5:0] sync_r;
	logic pin_s, bat_s, vin_s, chg_s, win_s, flt_s;
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			meta_r <= 6'h00;
			sync_r <= 6'h00;
		end else begin
			meta_r <= {load_ctrl_pin, bat_present, vin_valid,
			           chg_enable, vin_in_window, load_fault};
			sync_r <= meta_r;
		end
	end
	assign {pin_s, bat_s, vin_s, chg_s, win_s, flt_s} = sync_r;

	// Filtered button
	pbsq_btn_if btn ();
	pbsq_btn_filter #(.DEB(DEB_CYC)) u_filt (
		.clk_sys         (clk_sys),
		.reset           (reset),
		.pushbutton_in_n (pushbutton_in_n),
		.btn             (btn)
	);

	// Registers
	logic [1:0]         wsel_r;   // button_wake_time_sel
	logic [1:0]         hsel_r;   // button_hold_time_sel
	logic               rec_r;    // recovery_mode_sel, 1 = high-Z
	logic               vreq_r;   // supply_required_sel
	logic               w1_r;     // wake_flag_first
	logic               w2_r;     // wake_flag_second
	logic               rf_r;     // Reset fault flag
	logic               en_r;     // output_enable_bit
	logic [VCODE_W-1:0] vcode_r;  // output_voltage_code
	logic               buck_r;   // Buck output enabled
	pbsq_mode_t         mode_r;   // Operating mode
	logic               ack_r;    // Bus answer cycle
	logic [31:0]        rdata_r;  // Read data
	logic               bus_on;   // Register bus alive in this mode
	logic               acc_wr;   // Write taken this edge
	logic               acc_rd;   // Read taken this edge
	logic               pb_clr;   // Control register read clears flags

	assign bus_on = (mode_r == MODE_ACT);
	assign acc_wr = avs_write & ack_r & bus_on;
	assign acc_rd = avs_read & ack_r;
	assign pb_clr = acc_rd & bus_on & (avs_address == OFS_PB);
	// Fixed one wait state: answer on the second edge of a request
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
	assign avs_readdata    = rdata_r;

	// Answer timing
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= (avs_read | avs_write) & ~ack_r;
		end
	end

	// Press timing
	logic [TW-1:0]   tick_cnt_r; // Divider to the ms step
	logic            tick;
	logic [MS_W-1:0] ms_r;       // Length of the current press
	logic [MS_W-1:0] ms_prev_r;
	logic            armed_r;    // Reset allowed for this press
	logic            btn_en;     // Button input honoured
	logic            ev_w1, ev_w2, ev_rst;
	assign tick = (tick_cnt_r == TW'(TICK - 1));
	assign btn_en = bat_s | (vin_s & chg_s);

	// Free running ms tick
	always_ff @(posedge clk_sys) begin
		if (reset || tick) begin
			tick_cnt_r <= '0;
		end else begin
			tick_cnt_r <= tick_cnt_r + 1'b1;
		end
	end

	// Press length in ms; saturates rather than wraps
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ms_r      <= '0;
			ms_prev_r <= '0;
		end else begin
			ms_prev_r <= ms_r;
			if (!btn.pressed || !btn_en) begin
				ms_r <= '0;
			end else if (tick && ms_r != '1) begin
				ms_r <= ms_r + 1'b1;
			end
		end
	end

	// Threshold crossings, one pulse each time ms_r reaches them; a supply drop in the
	// crossing cycle must not let an event slip through
	logic hit_hold, ms_step;
	assign ms_step = btn_en && (ms_prev_r != ms_r);
	assign ev_w1 = (ms_r == wake_ms(wsel_r, 1'b0)) &&
	               ms_step;
	assign ev_w2 = (ms_r == wake_ms(wsel_r, 1'b1)) &&
	               ms_step;
	assign hit_hold = (ms_r == hold_ms(hsel_r)) &&
	                  ms_step;
	// Optional supply window condition
	assign ev_rst = hit_hold & armed_r & (~vreq_r | win_s);

	// Rearm only after a release; a new press must pass hold time again
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			armed_r <= 1'b1;
		end else if (ev_rst) begin
			armed_r <= 1'b0;
		end else if (!btn.pressed) begin
			armed_r <= 1'b1;
		end
	end

	// Interrupt and reset pulses
	logic int_act, rst_act, int_trig, rst_trig;
	assign int_trig = (ev_w1 | ev_w2 | ev_rst) & bus_on;
	assign rst_trig = ev_rst & (mode_r != MODE_SHIP);
	pbsq_pulse #(.LEN(INT_CYC)) u_int (
		.clk_sys (clk_sys),
		.reset   (reset),
		.trig    (int_trig),
		.active  (int_act)
	);
	pbsq_pulse #(.LEN(RST_LEN)) u_rst (
		.clk_sys (clk_sys),
		.reset   (reset),
		.trig    (rst_trig),
		.active  (rst_act)
	);
	assign int_out_n   = ~int_act;
	assign reset_out_n = ~rst_act;

	// Sticky flags; a new event beats a clearing read
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			w1_r <= 1'b0;
			w2_r <= 1'b0;
			rf_r <= 1'b0;
		end else begin
			w1_r <= ev_w1 | (w1_r & ~pb_clr);
			w2_r <= ev_w2 | (w2_r & ~pb_clr);
			rf_r <= ev_rst | (rf_r & ~pb_clr);
		end
	end

	// Software-written configuration, per byte lane
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			wsel_r  <= 2'h0;
			hsel_r  <= 2'h0;
			rec_r   <= 1'b0;
			vreq_r  <= 1'b0;
			en_r    <= 1'b0;
			vcode_r <= RST_VCODE;
		end else if (acc_wr && avs_address == OFS_PB &&
		             avs_byteenable[0]) begin
			wsel_r <= avs_writedata[PB_WSEL +: 2];
			hsel_r <= avs_writedata[PB_HSEL +: 2];
			rec_r  <= avs_writedata[PB_REC];
			vreq_r <= avs_writedata[PB_VREQ];
		end else if (acc_wr && avs_address == OFS_LS) begin
			if (avs_byteenable[0]) begin
				en_r <= avs_writedata[LS_EN];
			end
			if (avs_byteenable[1]) begin
				vcode_r <= avs_writedata[LS_CODE +: VCODE_W];
			end
		end
	end

	// Mode and buck sequencing
	logic vin_prev_r;  // For supply connect edge
	logic vin_rise;
	logic buck_off_wr;
	assign vin_rise = vin_s & ~vin_prev_r;
	assign buck_off_wr = acc_wr && avs_address == OFS_SYS &&
	                     avs_byteenable[1] && avs_writedata[SYS_BOFF];
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			mode_r     <= MODE_ACT;
			buck_r     <= 1'b1;
			vin_prev_r <= 1'b0;
		end else begin
			vin_prev_r <= vin_s;
			unique case (mode_r)
				MODE_ACT: begin
					if (ev_rst && vin_s) begin
						buck_r <= 1'b1;
					end else if (ev_rst) begin
						// Battery only: park as selected
						mode_r <= rec_r ? MODE_HIZ : MODE_SHIP;
						buck_r <= rec_r;
					end else if (vin_rise) begin
						buck_r <= 1'b1;
					end else if (buck_off_wr) begin
						buck_r <= 1'b0;
					end
				end
				MODE_SHIP: begin
					// Only the button and supply sensing wake it
					if (ev_w1 || vin_rise) begin
						mode_r <= MODE_ACT;
						buck_r <= 1'b1;
					end
				end
				MODE_HIZ: begin
					if (vin_rise) begin
						mode_r <= MODE_ACT;
						buck_r <= 1'b1;
					end else if (ev_rst) begin
						buck_r <= 1'b1;
					end
				end
				default: begin
					mode_r <= MODE_ACT;
				end
			endcase
		end
	end
	assign buck_output_en = buck_r;

	// Load output selection
	logic ls_req;
	logic load_on_r, pass_r, pg_n_r;
	logic [11:0] tgt_r;
	assign ls_req = en_r | (pin_s & (mode_r != MODE_SHIP));
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			load_on_r <= 1'b0;
			pass_r    <= 1'b1;
			tgt_r     <= LDO_BASE;
			pg_n_r    <= 1'b1;
		end else begin
			// Fault overrides both enables; ship mode shuts it off
			load_on_r <= ls_req & ~flt_s & (mode_r != MODE_SHIP);
			pass_r    <= (vcode_r > VCODE_3V3);
			tgt_r     <= LDO_BASE + 12'(vcode_r) * LDO_STEP;
			pg_n_r    <= ~(vin_s & bus_on);
		end
	end
	assign load_on           = load_on_r;
	assign load_pass_through = pass_r;
	assign load_pulldown     = ~load_on_r;
	assign ldo_target_mv     = tgt_r;
	assign power_good_out_n  = pg_n_r;

	// Read data; dead register bus reads zero
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			rdata_r <= 32'h0000_0000;
		end else if (avs_read && !ack_r) begin
			rdata_r <= 32'h0000_0000;
			if (bus_on) begin
				unique case (avs_address)
					OFS_PB: begin
						rdata_r[PB_WSEL +: 2] <= wsel_r;
						rdata_r[PB_HSEL +: 2] <= hsel_r;
						rdata_r[PB_REC]       <= rec_r;
						rdata_r[PB_VREQ]      <= vreq_r;
						rdata_r[PB_W1]        <= w1_r;
						rdata_r[PB_W2]        <= w2_r;
						rdata_r[PB_RF]        <= rf_r;
					end
					OFS_LS: begin
						rdata_r[LS_EN]              <= en_r;
						rdata_r[LS_CODE +: VCODE_W] <= vcode_r;
					end
					OFS_SYS: begin
						rdata_r[6:0] <= {btn.pressed, btn_en, pass_r,
						                 load_on_r, mode_r, buck_r};
					end
					default: begin
						rdata_r <= 32'h0000_0000; // Unmapped
					end
				endcase
			end
		end
	end

	// Independent memory of a reset issued during the current press
	logic seen_rst_r;
	always_ff @(posedge clk_sys) begin
		if (reset || !btn.pressed) begin
			seen_rst_r <= 1'b0;
		end else if (rst_trig) begin
			seen_rst_r <= 1'b1;
		end
	end

	// Checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	load_pin_on_a: assert property (
		pin_s && !flt_s && mode_r == MODE_ACT |=> load_on)
		else $error("load not on with pin high");
	ldo_target_a: assert property (
		!reset |=>
		ldo_target_mv == LDO_BASE + 12'($past(vcode_r)) * LDO_STEP)
		else $error("wrong output target");
	pass_mode_a: assert property (
		vcode_r > VCODE_3V3 |=> load_pass_through)
		else $error("no pass-through above 3.3 V");
	both_low_a: assert property (
		!en_r && !pin_s |=> !load_on)
		else $error("load on with both enables low");
	pulldown_a: assert property (
		(!en_r && !pin_s) || flt_s |=> load_pulldown)
		else $error("pull-down off while disabled");
	btn_gate_a: assert property (
		!btn_en |-> (!ev_w1 && !ev_rst) ##1 ms_r == '0)
		else $error("button event while not honoured");
	wake_int_a: assert property (
		ev_w1 && bus_on |=> !int_out_n [*8])
		else $error("no interrupt pulse on wake");
	flag_hold_a: assert property (
		w1_r && !pb_clr |=> w1_r)
		else $error("wake flag lost without read");
	rst_out_a: assert property (
		ev_rst && mode_r == MODE_ACT |=> !reset_out_n && !int_out_n)
		else $error("reset or interrupt missing");
	one_reset_a: assert property (
		seen_rst_r |-> !rst_trig)
		else $error("second reset in one press");
	recovery_a: assert property (
		ev_rst && !vin_s && mode_r == MODE_ACT |=>
		mode_r == (rec_r ? MODE_HIZ : MODE_SHIP))
		else $error("wrong recovery mode");
	resume_a: assert property (
		ev_rst && vin_s && mode_r == MODE_ACT |=>
		mode_r == MODE_ACT && buck_output_en)
		else $error("did not resume with supply");
	cov_wake_c:  cover property (ev_w1 && bus_on);
	cov_reset_c: cover property (ev_rst ##1 !reset_out_n);
	cov_ship_c:  cover property (mode_r == MODE_SHIP ##1 mode_r == MODE_ACT);
	cov_pass_c:  cover property (load_on && load_pass_through);
	cov_press_c: cover property (btn.fall);
endmodule // pbsq_top
`default_nettype wire

// ===== tb/pbsq_host_model.sv
// Host and push-button model facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module pbsq_host_model (
	// Clock
	input  wire logic       clk_sys,
	// Host notify line from the device
	input  wire logic       int_out_n,
	// Button contact and pulse report
	output var logic        pushbutton_in_n,
	output var logic [15:0] int_len,
	output var logic        int_seen
);
	logic [15:0] low_cnt;   // Cycles the notify line has been low

	// Button idles high: the contact has a pull-up
	initial begin
		pushbutton_in_n = 1'b1;
		int_len = 16'h0000;
		int_seen = 1'b0;
		low_cnt = 16'h0000;
	end

	// Measure each notify pulse, report its length once it ends
	always @(posedge clk_sys) begin
		int_seen <= 1'b0;
		if (int_out_n === 1'b0) begin
			low_cnt <= low_cnt + 16'h0001;
		end else if (low_cnt != 16'h0000) begin
			int_len <= low_cnt;
			int_seen <= 1'b1;
			low_cnt <= 16'h0000;
		end
	end

	// Hold the button down for n cycles; never called while supply ramps
	task automatic press(input int n);
		@(posedge clk_sys);
		pushbutton_in_n <= 1'b0;
		repeat (n) @(posedge clk_sys);
		pushbutton_in_n <= 1'b1;
	endtask
endmodule // pbsq_host_model
`default_nettype wire

// ===== tb/test_pushbutton_reset_and_load_switch_ctrl.sv
// Self-checking bench for the push-button sequencer and load selector
`timescale 1ns/1ps
`default_nettype none
module test_pushbutton_reset_and_load_switch_ctrl import pbsq_pkg::*;;
	logic        clk_sys = 1'b0;
	logic        reset = 1'b1;
	logic [3:0]  avs_address = 4'h0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h00000000;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	wire logic   pushbutton_in_n;
	logic        load_ctrl_pin = 1'b0;
	logic        bat_present = 1'b1;
	logic        vin_valid = 1'b1;
	logic        chg_enable = 1'b0;
	logic        load_fault = 1'b0;
	logic        int_out_n, reset_out_n, power_good_out_n;
	logic        load_on, load_pass_through, load_pulldown, buck_output_en;
	logic [11:0] ldo_target_mv;
	logic [15:0] int_len;
	logic        int_seen;
	int          err_count = 0;
	int          n_tests = 0;
	int          rst_low = 0;   // Cycles the reset output was seen low
	integer      seed = 54527;
	logic [63:0] q_rd[$];    // Expected read data, mask in upper half
	logic [14:0] q_ld[$];    // Expected on, pull-down, pass, target
	logic [15:0] q_int[$];   // Expected notify pulse lengths
	logic [63:0] rv;
	logic [14:0] lv;
	event        ld_ev;
	// Press length, expected pulse and flags per button case
	int          plen[6] = '{3000, 5000, 200, 3000, 3000, 11000};
	int          ilen[6] = '{2560, 4560, 0, 0, 2560, 4560};
	logic [31:0] fl[6] = '{32'h100, 32'h300, 32'h0, 32'h0, 32'h100, 32'h700};

	// Short tick and reset pulse keep the run brief; a hold still fits
	pbsq_top #(.TICK(2), .RST_LEN(50)) pbsq_top_i (
		.clk_sys(clk_sys), .reset(reset),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hF), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.pushbutton_in_n(pushbutton_in_n), .load_ctrl_pin(load_ctrl_pin),
		.bat_present(bat_present), .vin_valid(vin_valid),
		.chg_enable(chg_enable), .vin_in_window(1'b1),
		.load_fault(load_fault), .int_out_n(int_out_n),
		.reset_out_n(reset_out_n), .power_good_out_n(power_good_out_n),
		.load_on(load_on), .load_pass_through(load_pass_through),
		.load_pulldown(load_pulldown), .ldo_target_mv(ldo_target_mv),
		.buck_output_en(buck_output_en));
	pbsq_host_model pbsq_host_model_i (
		.clk_sys(clk_sys), .int_out_n(int_out_n),
		.pushbutton_in_n(pushbutton_in_n), .int_len(int_len),
		.int_seen(int_seen));

	// 20 MHz clock
	always #25 clk_sys = ~clk_sys;

	// Single comparison point
	task automatic chk(input string nm, input logic [31:0] s, e);
		n_tests++;
		if (s !== e) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask

	// Verdict and end of run
	task tally_and_finish;
		$display("Checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// One Avalon transfer; held until waitrequest is seen low at an edge
	task automatic bus(input logic wr, input logic [3:0] a,
			input logic [31:0] d);
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= ~wr;
		@(posedge clk_sys);
		while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	// Read with a noted expectation
	task automatic rd(input logic [3:0] a, input logic [31:0] m, e);
		q_rd.push_back({m, e});
		bus(1'b0, a, 32'h00000000);
	endtask

	// Note load outputs once the pin synchronisers have settled
	task automatic ld_expect(input logic on, input logic [4:0] c);
		repeat (6) @(posedge clk_sys);
		@(negedge clk_sys);
		q_ld.push_back({on, ~on, c > 5'h19,
			12'(16'd800 + 16'(c) * 16'd100)});
		-> ld_ev;
		@(posedge clk_sys); // Back on the driving edge
	endtask

	// Read data is taken at the edge that sees waitrequest low
	always @(posedge clk_sys) begin
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
			rv = q_rd.pop_front();
			chk("readdata", avs_readdata & rv[63:32], rv[31:0]);
		end
	end

	// Load output monitor
	always @(ld_ev) begin
		lv = q_ld.pop_front();
		chk("load_on", 32'(load_on), 32'(lv[14]));
		chk("pulldown", 32'(load_pulldown), 32'(lv[13]));
		chk("pass", 32'(load_pass_through), 32'(lv[12]));
		chk("target", 32'(ldo_target_mv), 32'(lv[11:0]));
	end

	// Notify pulse monitor; an unnoted pulse is a mismatch
	always @(posedge clk_sys) begin
		if (int_seen === 1'b1) begin
			if (q_int.size() == 0)
				chk("int_extra", 32'h1, 32'h0);
			else
				chk("int_len", 32'(int_len), 32'(q_int.pop_front()));
		end
	end

	// Reset output monitor: counts low cycles of each press
	always @(posedge clk_sys) begin
		if (reset_out_n === 1'b0)
			rst_low++;
	end

	// Main sequence
	initial begin
		logic [4:0] code;
		logic       en;
		repeat (10) @(posedge clk_sys);
		reset <= 1'b0;
		rd(OFS_LS, 32'h00001F01, 32'h00001F00);
		bus(1'b1, OFS_PB, 32'h00000003);
		rd(OFS_PB, 32'h0000073F, 32'h00000003);
		// Every enable/pin pair, both sides of the pass-through limit
		for (int i = 0; i < 13; i++) begin
			code = (i < 4) ? 5'h19 : (i < 8) ? 5'h1A : 5'($random(seed));
			en = i[0];
			load_ctrl_pin <= i[1];
			load_fault <= (i == 11);
			bus(1'b1, OFS_LS, {19'h0, code, 7'h0, en});
			rd(OFS_LS, 32'h00001F01, {19'h0, code, 7'h0, en});
			ld_expect((en | i[1]) & (i != 11), code);
		end
		// Unmapped place ignores writes and reads zero
		bus(1'b1, 4'hC, 32'hFFFFFFFF);
		rd(4'hC, 32'hFFFFFFFF, 32'h00000000);
		// Buck off, then back on at a supply connect
		rd(OFS_SYS, 32'h00000007, 32'h00000001);
		bus(1'b1, OFS_SYS, 32'h00000100);
		rd(OFS_SYS, 32'h00000001, 32'h00000000);
		vin_valid <= 1'b0;
		repeat (6) @(posedge clk_sys);
		chk("pg_n", 32'(power_good_out_n), 32'h1);
		vin_valid <= 1'b1;
		repeat (6) @(negedge clk_sys);
		chk("buck_en", 32'(buck_output_en), 32'h1);
		chk("pg_n", 32'(power_good_out_n), 32'h0);
		@(posedge clk_sys);
		// Presses: wake one, wake two, glitch, refused, charger, reset
		for (int k = 0; k < 6; k++) begin
			bat_present <= (k < 3) || (k == 5);
			chg_enable <= (k == 4);
			repeat (5) @(posedge clk_sys);
			if (ilen[k] != 0)
				q_int.push_back(16'(ilen[k]));
			if (k == 5)
				q_int.push_back(16'(INT_CYC));
			rst_low = 0;
			pbsq_host_model_i.press(plen[k]);
			repeat (4000) @(posedge clk_sys);
			chk("rst_len", rst_low, 32'(k == 5) * 32'h32);
			rd(OFS_PB, 32'h00000700, fl[k]);
			rd(OFS_PB, 32'h00000700, 32'h00000000);
		end
		rd(OFS_SYS, 32'h00000007, 32'h00000001);
		chk("int_pending", 32'(q_int.size()), 32'h0);
		tally_and_finish;
	end

	// Watchdog: the sequence needs roughly 50000 cycles
	initial begin
		repeat (100000) @(posedge clk_sys);
		err_count++;
		tally_and_finish;
	end
endmodule // test_pushbutton_reset_and_load_switch_ctrl
`default_nettype wire
